//--- hdl/crt_attr_pkg.sv
package crt_attr_pkg;

	// Register word indexes on the Avalon-MM slave
	localparam logic [1:0] REG_CTRL     = 2'h0;
	localparam logic [1:0] REG_UNDERLN  = 2'h1;
	localparam logic [1:0] REG_INTERVAL = 2'h2;
	localparam logic [1:0] REG_STATUS   = 2'h3;

	// Control register fields
	localparam int CTRL_DMA_EN    = 0;
	localparam int CTRL_BURST_LO  = 1;
	localparam int CTRL_BURST_HI  = 2;
	localparam logic [2:0] CTRL_RESET = 3'h0;

	// Burst size codes: one, two, four or eight characters
	localparam logic [1:0] BURST_1 = 2'h0;
	localparam logic [1:0] BURST_2 = 2'h1;
	localparam logic [1:0] BURST_4 = 2'h2;
	localparam logic [1:0] BURST_8 = 2'h3;
	localparam logic [3:0] LEN_1   = 4'h1;
	localparam logic [3:0] LEN_2   = 4'h2;
	localparam logic [3:0] LEN_4   = 4'h4;
	localparam logic [3:0] LEN_8   = 4'h8;

	localparam logic [3:0] UNDERLN_RESET  = 4'h8;
	localparam logic [7:0] INTERVAL_RESET = 8'h00;

	// Status register fields
	localparam int ST_BLANK = 0;
	localparam int ST_STOP  = 1;
	localparam int ST_REQ   = 2;
	localparam int ST_BLINK = 3;

	// Blink divides the frame rate by 32: phase is bit 4 of frame count
	localparam int BLINK_BIT = 4;

	// Decode tables, nibble per code, {line1, line0, suppress, light}
	localparam logic [63:0] TBL_ABOVE = 64'h0002_0442_4442_4422;
	localparam logic [63:0] TBL_ON    = 64'h0002_0141_18C1_C8C8;
	localparam logic [63:0] TBL_BELOW = 64'h0002_0442_2444_2244;

	localparam logic [3:0] CODE_TOP_LEFT = 4'h0;
	localparam logic [3:0] CODE_TOP_X    = 4'h4;
	localparam logic [3:0] CODE_VERT     = 4'h9;
	localparam logic [3:0] CODE_SPECIAL  = 4'hC;

	typedef enum logic [2:0] {
		DMA_IDLE  = 3'b001,
		DMA_BURST = 3'b010,
		DMA_GAP   = 3'b100
	} dma_state_t;

endpackage : crt_attr_pkg

//--- hdl/crt_attribute_decoder.sv
// What this block does
// - End-of-screen code holds video suppress until the frame ends.
// - Stop-DMA end-of-screen code halts requests for the frame and blanks.
// - DMA requests come singly or in bursts of 2, 4 or 8.
// - Software sets the idle interval between bursts.
// - Code 0000 gives 0010 above, 1000 on, 0100 below underline.
// - Code 0001 gives 0010 above, 1100 on, 0100 below underline.
// - Code 0010 gives 0100 above, 1000 on, 0010 below underline.
// - Code 0011 gives 0100 above, 1100 on, 0010 below underline.
// - Code 0100 gives 0010 above, 0001 on, 0100 below underline.
// - Code 0101 gives 0100 above, 1100 on, 0100 below underline.
// - Code 0110 gives 0100 above, 1000 on, 0100 below underline.
// - Code 0111 gives 0100 above, 0001 on, 0010 below underline.
// - Code 1000 gives 0010 above, 0001 on, 0010 below underline.
// - Code 1001 gives 0100 in every region.
// - Code 1010 gives 0100 above, 0001 on, 0100 below underline.
// - Code 1011 drives all four outputs low everywhere.
// - Code 1100 asserts only video suppress, blanking the position.
// - Codes 1101 to 1111 are illegal; the controller never stores them.
// - Blink bit set makes the position blink.
// - Intensify bit set drives the intensify output.
// - Blink gates video suppress at frame rate divided by 32.
// - Either retrace output active also asserts video suppress.
// - Light enable acts independently of video suppress.
`timescale 1ns/10ps
module crt_attribute_decoder (
	input  wire logic        i_clk,
	input  wire logic        i_rst_n,
	input  wire logic        i_ce,
	input  wire logic [1:0]  i_avs_address,
	input  wire logic        i_avs_read,
	input  wire logic        i_avs_write,
	input  wire logic [31:0] i_avs_writedata,
	output logic      [31:0] o_avs_readdata,
	output logic             o_avs_waitrequest,
	input  wire logic        i_char_valid,
	input  wire logic        i_is_attr,
	input  wire logic [3:0]  i_graphic_attr_code,
	input  wire logic        i_blink_bit,
	input  wire logic        i_intensify_bit,
	input  wire logic [3:0]  i_line_count,
	input  wire logic        i_horiz_retrace,
	input  wire logic        i_vert_retrace,
	input  wire logic        i_frame_end,
	input  wire logic        i_end_screen,
	input  wire logic        i_end_screen_stop,
	input  wire logic        i_dma_ack,
	output logic             o_dma_req,
	output logic             o_video_suppress,
	output logic             o_light_enable_out,
	output logic             o_line_attr_bit0,
	output logic             o_line_attr_bit1,
	output logic             o_intensify_out,
	output logic             o_horiz_retrace_out,
	output logic             o_vert_retrace_out
);

	localparam int BLINK_BIT_W = crt_attr_pkg::BLINK_BIT + 1;

	logic [2:0]                   ctrl_q;
	logic [3:0]                   underln_q;
	logic [7:0]                   interval_q;
	logic                         resp_q;
	logic                         bus_req;
	logic                         blank_q;
	logic                         blank_d;
	logic                         stop_q;
	logic                         stop_d;
	logic [BLINK_BIT_W-1:0]       frame_cnt_q;
	logic                         blink_phase;
	crt_attr_pkg::dma_state_t     state_q;
	logic [3:0]                   beat_q;
	logic [7:0]                   gap_q;
	logic [3:0]                   burst_len;
	logic [63:0]                  table_sel;
	logic [3:0]                   attr_out;
	logic                         is_graphic;
	logic                         attr_vsp;

	// One wait cycle per access keeps read data registered
	// Writes land only on the edge that sees waitrequest low
	assign bus_req = i_avs_read | i_avs_write;
	assign o_avs_waitrequest = bus_req & ~resp_q;

	always_ff @(posedge i_clk)
	begin
		if (!i_rst_n)
			resp_q <= 1'b0;
		else if (i_ce)
			resp_q <= bus_req & ~resp_q;
	end

	always_ff @(posedge i_clk)
	begin
		if (!i_rst_n)
		begin
			ctrl_q     <= crt_attr_pkg::CTRL_RESET;
			underln_q  <= crt_attr_pkg::UNDERLN_RESET;
			interval_q <= crt_attr_pkg::INTERVAL_RESET;
		end
		else if (i_ce && i_avs_write && resp_q)
		begin
			case (i_avs_address)
				crt_attr_pkg::REG_CTRL:
					ctrl_q <= i_avs_writedata[2:0];
				crt_attr_pkg::REG_UNDERLN:
					underln_q <= i_avs_writedata[3:0];
				crt_attr_pkg::REG_INTERVAL:
					interval_q <= i_avs_writedata[7:0];
				default:
					ctrl_q <= ctrl_q;
			endcase
		end
	end

	// Unmapped or status-write accesses are ignored; reads answer zero
	always_ff @(posedge i_clk)
	begin
		if (!i_rst_n)
			o_avs_readdata <= 32'h0000_0000;
		else if (i_ce && i_avs_read && !resp_q)
		begin
			o_avs_readdata <= 32'h0000_0000;
			case (i_avs_address)
				crt_attr_pkg::REG_CTRL:
					o_avs_readdata[2:0] <= ctrl_q;
				crt_attr_pkg::REG_UNDERLN:
					o_avs_readdata[3:0] <= underln_q;
				crt_attr_pkg::REG_INTERVAL:
					o_avs_readdata[7:0] <= interval_q;
				crt_attr_pkg::REG_STATUS:
				begin
					o_avs_readdata[crt_attr_pkg::ST_BLANK] <= blank_q;
					o_avs_readdata[crt_attr_pkg::ST_STOP]  <= stop_q;
					o_avs_readdata[crt_attr_pkg::ST_REQ]   <= o_dma_req;
					o_avs_readdata[crt_attr_pkg::ST_BLINK] <= blink_phase;
				end
				default:
					o_avs_readdata <= 32'h0000_0000;
			endcase
		end
	end

	// frame blank hold
	// Set wins over the frame-end clear so a late code still blanks
	assign blank_d = i_end_screen | i_end_screen_stop |
		(blank_q & ~i_frame_end);
	assign stop_d = i_end_screen_stop | (stop_q & ~i_frame_end);

	always_ff @(posedge i_clk)
	begin
		if (!i_rst_n)
		begin
			blank_q <= 1'b0;
			stop_q  <= 1'b0;
		end
		else if (i_ce)
		begin
			blank_q <= blank_d;
			stop_q  <= stop_d;
		end
	end

	always_ff @(posedge i_clk)
	begin
		if (!i_rst_n)
			frame_cnt_q <= '0;
		else if (i_ce && i_frame_end)
			frame_cnt_q <= frame_cnt_q + 1'b1;
	end
	assign blink_phase = frame_cnt_q[crt_attr_pkg::BLINK_BIT];

	always_comb
	begin
		case (ctrl_q[crt_attr_pkg::CTRL_BURST_HI:crt_attr_pkg::CTRL_BURST_LO])
			crt_attr_pkg::BURST_2: burst_len = crt_attr_pkg::LEN_2;
			crt_attr_pkg::BURST_4: burst_len = crt_attr_pkg::LEN_4;
			crt_attr_pkg::BURST_8: burst_len = crt_attr_pkg::LEN_8;
			default:               burst_len = crt_attr_pkg::LEN_1;
		endcase
	end

	assign o_dma_req = (state_q == crt_attr_pkg::DMA_BURST) & ~stop_q;

	always_ff @(posedge i_clk)
	begin
		if (!i_rst_n)
		begin
			state_q <= crt_attr_pkg::DMA_IDLE;
			beat_q  <= '0;
			gap_q   <= '0;
		end
		else if (i_ce)
		begin
			case (state_q)
				crt_attr_pkg::DMA_IDLE:
					if (ctrl_q[crt_attr_pkg::CTRL_DMA_EN] && !stop_q)
					begin
						state_q <= crt_attr_pkg::DMA_BURST;
						beat_q  <= burst_len;
					end
				crt_attr_pkg::DMA_BURST:
					if (stop_q)
						state_q <= crt_attr_pkg::DMA_IDLE;
					else if (i_dma_ack)
					begin
						beat_q <= beat_q - 1'b1;
						if (beat_q == crt_attr_pkg::LEN_1)
						begin
							gap_q   <= interval_q;
							state_q <= (interval_q == '0) ?
								crt_attr_pkg::DMA_IDLE :
								crt_attr_pkg::DMA_GAP;
						end
					end
				crt_attr_pkg::DMA_GAP:
				begin
					gap_q <= gap_q - 1'b1;
					if (gap_q == 8'h01)
						state_q <= crt_attr_pkg::DMA_IDLE;
				end
				default:
					state_q <= crt_attr_pkg::DMA_IDLE;
			endcase
		end
	end

	always_comb
	begin
		if (i_line_count < underln_q)
			table_sel = crt_attr_pkg::TBL_ABOVE;
		else if (i_line_count == underln_q)
			table_sel = crt_attr_pkg::TBL_ON;
		else
			table_sel = crt_attr_pkg::TBL_BELOW;
	end

	// blank code; illegal codes read zero
	assign attr_out   = table_sel[{i_graphic_attr_code, 2'b00} +: 4];
	assign is_graphic = i_char_valid & i_is_attr;
	assign attr_vsp   = is_graphic &
		(attr_out[1] | (i_blink_bit & blink_phase));

	always_ff @(posedge i_clk)
	begin
		if (!i_rst_n)
		begin
			o_video_suppress    <= 1'b0;
			o_light_enable_out  <= 1'b0;
			o_line_attr_bit0    <= 1'b0;
			o_line_attr_bit1    <= 1'b0;
			o_intensify_out     <= 1'b0;
			o_horiz_retrace_out <= 1'b0;
			o_vert_retrace_out  <= 1'b0;
		end
		else if (i_ce)
		begin
			o_video_suppress <= i_horiz_retrace | i_vert_retrace |
				blank_d | attr_vsp;
			o_light_enable_out  <= is_graphic & attr_out[0];
			o_line_attr_bit0    <= is_graphic & attr_out[2];
			o_line_attr_bit1    <= is_graphic & attr_out[3];
			o_intensify_out     <= is_graphic & i_intensify_bit;
			o_horiz_retrace_out <= i_horiz_retrace;
			o_vert_retrace_out  <= i_vert_retrace;
		end
	end

	hold_blank_a: assert property (
		@(posedge i_clk) disable iff (!i_rst_n)
		(i_ce && i_end_screen) ##1 (!i_ce || !i_frame_end)[*2]
		|-> o_video_suppress && blank_q)
		else $error("blank not held after end-of-screen");

	stop_dma_a: assert property (
		@(posedge i_clk) disable iff (!i_rst_n)
		(i_ce && i_end_screen_stop) |=> !o_dma_req && o_video_suppress)
		else $error("request seen after stop code");

	burst_len_a: assert property (
		@(posedge i_clk) disable iff (!i_rst_n)
		(state_q == crt_attr_pkg::DMA_BURST &&
		$past(state_q) == crt_attr_pkg::DMA_IDLE) |-> beat_q == burst_len)
		else $error("burst length mismatch");

	gap_load_a: assert property (
		@(posedge i_clk) disable iff (!i_rst_n)
		(state_q == crt_attr_pkg::DMA_GAP &&
		$past(state_q) == crt_attr_pkg::DMA_BURST)
		|-> gap_q == interval_q && !o_dma_req)
		else $error("gap not loaded from interval");

	corner_decode_a: assert property (
		@(posedge i_clk) disable iff (!i_rst_n)
		(i_ce && is_graphic && !i_blink_bit &&
		i_graphic_attr_code == crt_attr_pkg::CODE_TOP_LEFT &&
		i_line_count == underln_q) |=>
		o_line_attr_bit1 && !o_line_attr_bit0 && !o_light_enable_out)
		else $error("top left corner wrong on underline");

	top_x_a: assert property (
		@(posedge i_clk) disable iff (!i_rst_n)
		(i_ce && is_graphic &&
		i_graphic_attr_code == crt_attr_pkg::CODE_TOP_X &&
		i_line_count == underln_q) |=>
		o_light_enable_out && !o_line_attr_bit1 && !o_line_attr_bit0)
		else $error("top intersect wrong on underline");

	vert_line_a: assert property (
		@(posedge i_clk) disable iff (!i_rst_n)
		(i_ce && is_graphic &&
		i_graphic_attr_code == crt_attr_pkg::CODE_VERT) |=>
		o_line_attr_bit0 && !o_line_attr_bit1 && !o_light_enable_out)
		else $error("vertical line wrong");

	special_code_a: assert property (
		@(posedge i_clk) disable iff (!i_rst_n)
		(i_ce && is_graphic &&
		i_graphic_attr_code == crt_attr_pkg::CODE_SPECIAL) |=>
		o_video_suppress && !o_line_attr_bit0 &&
		!o_line_attr_bit1 && !o_light_enable_out)
		else $error("special code not blank");

	retrace_blank_a: assert property (
		@(posedge i_clk) disable iff (!i_rst_n)
		(i_ce && (i_horiz_retrace || i_vert_retrace)) |=>
		o_video_suppress)
		else $error("retrace without suppress");

	intensify_out_a: assert property (
		@(posedge i_clk) disable iff (!i_rst_n)
		(i_ce && is_graphic && i_intensify_bit) |=> o_intensify_out)
		else $error("intensify not driven");

endmodule : crt_attribute_decoder

//--- tb/dma_partner.sv
`timescale 1ns/10ps
module dma_partner (
	input  wire logic i_clk,
	input  wire logic i_rst_n,
	input  wire logic i_slow,
	input  wire logic i_req,
	output logic      o_ack
);
	logic skip_q;

	// Slow mode stalls every other clock
	always_ff @(posedge i_clk)
	begin
		if (!i_rst_n || !i_slow)
			skip_q <= 1'b0;
		else
			skip_q <= ~skip_q;
	end

	assign o_ack = i_req & ~skip_q;
endmodule : dma_partner

//--- tb/crt_attribute_decoder_tb_top.sv
`timescale 1ns/10ps
`define CHK(nm, e, g) begin cmp_count++; if ((e) !== (g)) begin bad_count++; \
	$display("[ERR] %s exp %0h got %0h", nm, e, g); end end
module crt_attribute_decoder_tb_top;
	logic        i_clk, i_rst_n, rd, wr, valid, attr, bl, hi, hr, vr, fe;
	logic        es, ess, ack, slow, wt, req, video_suppress, light_enable_out, la0, la1, hg, hro, vro;
	logic        ce;
	logic [1:0]  addr;
	logic [3:0]  code, lc;
	logic [31:0] wd, rdat, q;
	int          bad_count, cmp_count, ack_cnt, n, a;
	// Rows: above, on, below nibbles of {line1, line0, suppress, light}
	localparam logic [11:0] TBL [13] = '{
		12'h284,
		12'h2C4,
		12'h482,
		12'h4C2,
		12'h214,
		12'h4C4,
		12'h484,
		12'h412,
		12'h212,
		12'h444,
		12'h414,
		12'h000,
		12'h222
	};
	localparam logic [9:0] CFG [4] = '{10'h000, 10'h102, 10'h205, 10'h301};

	crt_attribute_decoder dut_u (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_ce(ce),
		.i_avs_address(addr), .i_avs_read(rd), .i_avs_write(wr),
		.i_avs_writedata(wd), .o_avs_readdata(rdat), .o_avs_waitrequest(wt),
		.i_char_valid(valid), .i_is_attr(attr), .i_graphic_attr_code(code),
		.i_blink_bit(bl), .i_intensify_bit(hi), .i_line_count(lc),
		.i_horiz_retrace(hr), .i_vert_retrace(vr), .i_frame_end(fe),
		.i_end_screen(es), .i_end_screen_stop(ess), .i_dma_ack(ack),
		.o_dma_req(req), .o_video_suppress(video_suppress), .o_light_enable_out(light_enable_out),
		.o_line_attr_bit0(la0), .o_line_attr_bit1(la1), .o_intensify_out(hg),
		.o_horiz_retrace_out(hro), .o_vert_retrace_out(vro));
	dma_partner far_u (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_slow(slow),
		.i_req(req), .o_ack(ack));

	// Counted by non-blocking update so readers at the same edge see no race
	always @(posedge i_clk)
		if (!i_rst_n)
			ack_cnt <= 0;
		else if (ack)
			ack_cnt <= ack_cnt + 1;

	task automatic complete_run();
		$display("checks %0d errors %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : complete_run

	task automatic limit(input int k, input int lim);
		if (k > lim)
		begin
			bad_count++;
			complete_run();
		end
	endtask : limit

	task automatic bus(input logic w, input logic [1:0] ad, input logic [31:0] d);
		int k;
		@(posedge i_clk);
		addr <= ad;
		wd <= d;
		wr <= w;
		rd <= ~w;
		k = 0;
		do
		begin
			@(posedge i_clk);
			k++;
			limit(k, 50);
		end
		while (wt !== 1'b0);
		// Read data are taken at the edge that accepts the request
		q = rdat;
		rd <= 1'b0;
		wr <= 1'b0;
	endtask : bus

	task automatic disp(input logic [3:0] c, input logic [3:0] l, input logic b);
		@(posedge i_clk);
		code <= c;
		lc <= l;
		bl <= b;
		hi <= b;
		@(posedge i_clk);
		// Outputs are read one edge after they are launched
		@(posedge i_clk);
	endtask : disp

	task automatic wait_req(input logic v);
		n = 0;
		while (req !== v)
		begin
			@(posedge i_clk);
			n++;
			limit(n, 400);
		end
	endtask : wait_req

	task automatic pulse_frames(input int k);
		repeat (k)
		begin
			@(posedge i_clk);
			fe <= 1'b1;
			@(posedge i_clk);
			fe <= 1'b0;
		end
	endtask : pulse_frames

	initial
	begin
		i_clk = 1'b0;
		forever #10 i_clk = ~i_clk;
	end

	initial
	begin
		{i_rst_n, rd, wr, valid, attr, bl, hi, hr, vr, fe, es, ess, slow} = '0;
		addr = '0;
		wd = '0;
		code = '0;
		lc = '0;
		bad_count = 0;
		cmp_count = 0;
		ce = 1'b1;
		repeat (12) @(posedge i_clk);
		`CHK("reset", 3'b000, {req, video_suppress, hg})
		i_rst_n <= 1'b1;
		bus(1'b0, crt_attr_pkg::REG_UNDERLN, '0);
		`CHK("underline", 32'h0000_0008, q)
		bus(1'b0, crt_attr_pkg::REG_INTERVAL, '0);
		`CHK("interval", 32'h0000_0000, q)
		// Status is read only
		bus(1'b1, crt_attr_pkg::REG_STATUS, 32'h0000_000F);
		bus(1'b0, crt_attr_pkg::REG_STATUS, '0);
		`CHK("status", 32'h0000_0000, q)
		valid <= 1'b1;
		attr <= 1'b1;
		for (int c = 0; c < 13; c++)
			for (int r = 0; r < 3; r++)
			begin
				disp(4'(c), 4'(7 + r), 1'b0);
				`CHK("attr", TBL[c][11 - 4 * r -: 4], {la1, la0, video_suppress, light_enable_out})
			end
		bus(1'b1, crt_attr_pkg::REG_UNDERLN, 32'h0000_0003);
		disp(4'h0, 4'h3, 1'b0);
		`CHK("moved underline", 4'h8, {la1, la0, video_suppress, light_enable_out})
		disp(4'h9, 4'h1, 1'b1);
		`CHK("phase 0", 2'b01, {video_suppress, hg})
		pulse_frames(16);
		disp(4'h9, 4'h1, 1'b1);
		`CHK("blink on", 2'b11, {video_suppress, hg})
		disp(4'h9, 4'h1, 1'b0);
		`CHK("no blink", 2'b00, {video_suppress, hg})
		pulse_frames(16);
		hr <= 1'b1;
		disp(4'h4, 4'h3, 1'b0);
		`CHK("hretrace", 3'b111, {hro, video_suppress, light_enable_out})
		hr <= 1'b0;
		vr <= 1'b1;
		disp(4'h9, 4'h3, 1'b0);
		`CHK("vretrace", 2'b11, {vro, video_suppress})
		vr <= 1'b0;
		@(posedge i_clk);
		es <= 1'b1;
		@(posedge i_clk);
		es <= 1'b0;
		repeat (5) @(posedge i_clk);
		`CHK("screen end", 1'b1, video_suppress)
		bus(1'b0, crt_attr_pkg::REG_STATUS, '0);
		`CHK("blank flag", 32'h0000_0001, q)
		pulse_frames(1);
		repeat (3) @(posedge i_clk);
		`CHK("frame over", 1'b0, video_suppress)
		for (int i = 0; i < 4; i++)
		begin
			slow <= (i == 3);
			bus(1'b1, crt_attr_pkg::REG_INTERVAL, 32'(CFG[i][7:0]));
			bus(1'b1, crt_attr_pkg::REG_CTRL, {29'h0, CFG[i][9:8], 1'b1});
			wait_req(1'b1);
			wait_req(1'b0);
			wait_req(1'b1);
			a = ack_cnt;
			wait_req(1'b0);
			`CHK("burst", 32'(1 << CFG[i][9:8]), ack_cnt - a)
			wait_req(1'b1);
			`CHK("gap", CFG[i][7:0] + 1, n)
		end
		@(posedge i_clk);
		ess <= 1'b1;
		@(posedge i_clk);
		ess <= 1'b0;
		repeat (20) @(posedge i_clk);
		`CHK("stopped", 2'b01, {req, video_suppress})
		bus(1'b0, crt_attr_pkg::REG_STATUS, '0);
		`CHK("stop flags", 32'h0000_0003, q)
		bus(1'b0, crt_attr_pkg::REG_CTRL, '0);
		`CHK("ctrl", 32'h0000_0007, q)
		pulse_frames(1);
		wait_req(1'b1);
		`CHK("restart", 2, n)
		// Clock enable low must freeze every output except waitrequest
		ce <= 1'b0;
		hr <= 1'b1;
		repeat (3) @(posedge i_clk);
		`CHK("frozen", 3'b100, {req, hro, video_suppress})
		ce <= 1'b1;
		hr <= 1'b0;
		i_rst_n <= 1'b0;
		repeat (2) @(posedge i_clk);
		`CHK("reset out", 4'h0, {req, video_suppress, light_enable_out, hg})
		`CHK("reset attr", 4'h0, {la0, la1, hro, vro})
		i_rst_n <= 1'b1;
		bus(1'b0, crt_attr_pkg::REG_CTRL, '0);
		`CHK("ctrl reset", 32'h0000_0000, q)
		`CHK("no request", 1'b0, req)
		complete_run();
	end
endmodule : crt_attribute_decoder_tb_top
